// File: verilog/wsv_cfg.svh
// constants for the weld schedule sequencer: codes, limits, timing
// assumes line-cycle ticks arrive as one-clock pulses from outside
`ifndef WSV_CFG_SVH
`define WSV_CFG_SVH
`define WSV_CYC_NONREP   3'h0
`define WSV_CYC_REPEAT   3'h1
`define WSV_CYC_CHAIN    3'h2
`define WSV_CYC_SUCC     3'h3
`define WSV_CYC_CONDSUCC 3'h4
`define WSV_CYC_WAIT     3'h5
`define WSV_SLOPE_NONE   2'h0
`define WSV_SLOPE_UP     2'h1
`define WSV_SLOPE_DOWN   2'h2
`define WSV_WAIT_ENABLE  7'h05
`define WSV_PARK_VALUE   7'h63
`define WSV_EXIT1_SCHED  6'h0A
`define WSV_EXIT2_SCHED  6'h14
`define WSV_SLOPE_MAX    7'h63
`define WSV_BLINK_TICKS  9'h0FA
`endif

// File: verilog/wsv_pkg.sv
// types of the weld schedule sequencer
// assumes all counts are plain binary, 0 to 99
package wsv_pkg;
	typedef struct packed {
		logic [6:0] squeeze;
		logic [6:0] weld;
		logic [6:0] pct;
		logic [6:0] hold;
		logic [6:0] off;
		logic [6:0] impulses;
		logic [6:0] cool;
		logic [2:0] valve;
		logic [2:0] cycle_mode;
		logic [1:0] slope_mode;
		logic [6:0] slope_count;
	} wsv_sched_t;

	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_LOAD = 9'h002,
		ST_SQZ  = 9'h004,
		ST_UPS  = 9'h008,
		ST_WELD = 9'h010,
		ST_COOL = 9'h020,
		ST_DNS  = 9'h040,
		ST_HOLD = 9'h080,
		ST_OFF  = 9'h100
	} wsv_state_t;

	typedef struct packed {
		logic [2:0] valve;
		logic       fire;
		logic [6:0] current;
	} wsv_drive_t;
endpackage

// File: verilog/wsv_top.sv
// weld schedule sequencer: phases, valve decode, wait-here, slopes
// assumes the schedule store answers REC for SCHED_NUM and REC_NEXT for
// SCHED_NUM+1 within one clock; all inputs synchronous to CORE_CLK
`timescale 1ns/100ps
`include "wsv_cfg.svh"

// Overview of operation
// - valve code bits 0,1,2 drive valves one, two, three; 00 off, 07 all.
// - wait-here schedule from primary input parks in phase, valves held.
// - while parked, emergency stop or temperature limit aborts sequence.
// - while parked, first exit selects schedule 10, second selects 20.
// - park phase picked by value 99: squeeze, then impulses, then hold.
// - hold park needs squeeze and impulses not 99; weld park needs squeeze not 99.
// - weld/cool park repeats impulses until stop opens or exit input.
// - wait-here honoured only when wait enable setting equals 05.
// - slope counts 01 to 99 give ramp length in line cycles.
// - slope cycles add to weld cycles.
// - slope count and weld count are independent settings.
// - slope mode 00 fires straight at programmed percent.
// - slope mode 01 ramps up just before weld to programmed percent.
// - upslope only before first impulse and only on first initiation.
// - single schedule upslope starts at quarter percent, steps each cycle.
// - chained slope with zero weld ramps to next schedule percent.
// - downslope lowers current stepwise to low level over slope count.
// - slope mode 02 downslopes after weld, after last impulse only.
// - conditional successive holds valves, blinks hold, advances on initiation.
// - chained mode goes at once to next higher schedule.
module wsv_top (
	// clock and reset
	input  wire logic              CORE_CLK,
	input  wire logic              RST,
	// timebase
	input  wire logic              LINE_TICK,
	// initiation and stop inputs
	input  wire logic              PRIMARY_INITIATION_INPUT,
	input  wire logic              WAIT_EXIT_INPUT_FIRST,
	input  wire logic              WAIT_EXIT_INPUT_SECOND,
	input  wire logic              ESTOP_CLOSED,
	input  wire logic              TEMP_LIMIT_CLOSED,
	// settings
	input  wire logic [6:0]        WAIT_MODE_ENABLE,
	input  wire logic [5:0]        SCHED_SELECT,
	// schedule store
	input  wire wsv_pkg::wsv_sched_t REC,
	input  wire wsv_pkg::wsv_sched_t REC_NEXT,
	output logic [5:0]             SCHED_NUM,
	// drive toward valves and firing stage
	output logic [2:0]             VALVE,
	output logic                   FIRE,
	output logic [6:0]             CURRENT_PCT,
	// status
	output logic [8:0]             PHASE,
	output logic                   WAITING,
	output logic                   HOLD_BLINK
);
	wsv_pkg::wsv_state_t state_reg, state_next;
	wsv_pkg::wsv_sched_t rec_reg;
	wsv_pkg::wsv_drive_t drv_next;
	logic [6:0] next_pct_reg;
	logic [5:0] sched_reg, sched_next, home_reg, pend_reg;
	logic       pend_valid_reg;
	logic [6:0] cnt_reg, cnt_val, imp_reg;
	logic       ld_cnt, ld_sched, clr_primary, set_pend, repeat_ld;
	logic       primary_reg, up_ok_reg, csw_reg, csw_next;
	logic       start_prev, ex1_prev, ex2_prev;
	logic       start_rise, ex1_rise, ex2_rise, stop;
	logic       wh, sqz_park, imp_park, hold_park, parked, done;
	logic       chain_slope, up_req, dn_req;
	logic [6:0] up_s, up_e, ramp_diff, ramp_step;
	logic [6:0] cur_reg, end_reg, step_reg;
	logic       dir_up_reg;
	logic [8:0] blink_cnt;
	logic       blink_reg;

	assign start_rise = PRIMARY_INITIATION_INPUT & ~start_prev;
	assign ex1_rise   = WAIT_EXIT_INPUT_FIRST & ~ex1_prev;
	assign ex2_rise   = WAIT_EXIT_INPUT_SECOND & ~ex2_prev;
	assign stop       = ~ESTOP_CLOSED | ~TEMP_LIMIT_CLOSED;
	assign done       = (cnt_reg == 7'h00);

	// park selection, priority squeeze > impulses > hold
	assign wh = primary_reg && (rec_reg.cycle_mode == `WSV_CYC_WAIT)
		&& (WAIT_MODE_ENABLE == `WSV_WAIT_ENABLE);
	assign sqz_park  = wh && (rec_reg.squeeze == `WSV_PARK_VALUE);
	assign imp_park  = wh && !sqz_park && (rec_reg.impulses == `WSV_PARK_VALUE);
	assign hold_park = wh && !sqz_park && !imp_park
		&& (rec_reg.hold == `WSV_PARK_VALUE);
	assign parked = (state_reg == wsv_pkg::ST_SQZ && sqz_park)
		|| ((state_reg == wsv_pkg::ST_WELD || state_reg == wsv_pkg::ST_COOL) && imp_park)
		|| (state_reg == wsv_pkg::ST_HOLD && hold_park);

	// zero or out-of-range slope count means no ramp
	assign chain_slope = (rec_reg.slope_mode == `WSV_SLOPE_UP) && (rec_reg.weld == 7'h00)
		&& (rec_reg.cycle_mode == `WSV_CYC_CHAIN);
	assign up_req = up_ok_reg && (rec_reg.slope_mode == `WSV_SLOPE_UP)
		&& (rec_reg.slope_count != 7'h00)
		&& (rec_reg.slope_count <= `WSV_SLOPE_MAX);
	assign dn_req = (rec_reg.slope_mode == `WSV_SLOPE_DOWN) && (rec_reg.slope_count != 7'h00)
		&& (rec_reg.slope_count <= `WSV_SLOPE_MAX);
	assign up_s = chain_slope ? rec_reg.pct : {2'h0, rec_reg.pct[6:2]};
	assign up_e = chain_slope ? next_pct_reg : rec_reg.pct;
	always_comb begin
		if (state_reg == wsv_pkg::ST_WELD)
			ramp_diff = rec_reg.pct - {2'h0, rec_reg.pct[6:2]};
		else if (up_e >= up_s)
			ramp_diff = up_e - up_s;
		else
			ramp_diff = up_s - up_e;
		// divisor checked for zero below, so a zero slope count gives a zero step
		if (rec_reg.slope_count == 7'h00)
			ramp_step = 7'h00;
		else
			ramp_step = ramp_diff / rec_reg.slope_count;
	end

	always_comb begin
		state_next  = state_reg;
		ld_cnt      = 1'b0;
		cnt_val     = 7'h00;
		ld_sched    = 1'b0;
		sched_next  = sched_reg;
		clr_primary = 1'b0;
		set_pend    = 1'b0;
		repeat_ld   = 1'b0;
		csw_next    = csw_reg;
		case (state_reg)
			wsv_pkg::ST_IDLE: begin
				if (start_rise) begin
					ld_sched   = 1'b1;
					sched_next = pend_valid_reg ? pend_reg : SCHED_SELECT;
					state_next = wsv_pkg::ST_LOAD;
				end
			end
			wsv_pkg::ST_LOAD: begin
				ld_cnt     = 1'b1;
				cnt_val    = REC.squeeze;
				state_next = wsv_pkg::ST_SQZ;
			end
			wsv_pkg::ST_SQZ: begin
				if (done) begin
					ld_cnt = 1'b1;
					if (up_req) begin
						cnt_val    = rec_reg.slope_count;
						state_next = wsv_pkg::ST_UPS;
					end else begin
						cnt_val    = rec_reg.weld;
						state_next = wsv_pkg::ST_WELD;
					end
				end
			end
			wsv_pkg::ST_UPS: begin
				if (done) begin
					ld_cnt     = 1'b1;
					cnt_val    = rec_reg.weld;
					state_next = wsv_pkg::ST_WELD;
				end
			end
			wsv_pkg::ST_WELD: begin
				if (done) begin
					ld_cnt = 1'b1;
					if (imp_park || imp_reg > 7'h01) begin
						cnt_val    = rec_reg.cool;
						state_next = wsv_pkg::ST_COOL;
					end else if (dn_req) begin
						cnt_val    = rec_reg.slope_count;
						state_next = wsv_pkg::ST_DNS;
					end else begin
						cnt_val    = rec_reg.hold;
						state_next = wsv_pkg::ST_HOLD;
					end
				end
			end
			wsv_pkg::ST_COOL: begin
				if (done) begin
					ld_cnt     = 1'b1;
					cnt_val    = rec_reg.weld;
					state_next = wsv_pkg::ST_WELD;
				end
			end
			wsv_pkg::ST_DNS: begin
				if (done) begin
					ld_cnt     = 1'b1;
					cnt_val    = rec_reg.hold;
					state_next = wsv_pkg::ST_HOLD;
				end
			end
			wsv_pkg::ST_HOLD: begin
				if (csw_reg) begin
					if (start_rise) begin
						csw_next   = 1'b0;
						ld_sched   = 1'b1;
						sched_next = sched_reg + 6'h01;
						state_next = wsv_pkg::ST_LOAD;
					end
				end else if (done) begin
					case (rec_reg.cycle_mode)
						`WSV_CYC_REPEAT: begin
							ld_cnt     = 1'b1;
							cnt_val    = rec_reg.off;
							state_next = wsv_pkg::ST_OFF;
						end
						`WSV_CYC_CHAIN: begin
							ld_sched   = 1'b1;
							sched_next = sched_reg + 6'h01;
							state_next = wsv_pkg::ST_LOAD;
						end
						`WSV_CYC_CONDSUCC: csw_next = 1'b1;
						`WSV_CYC_SUCC: begin
							set_pend   = 1'b1;
							state_next = wsv_pkg::ST_IDLE;
						end
						default: state_next = wsv_pkg::ST_IDLE;
					endcase
				end
			end
			wsv_pkg::ST_OFF: begin
				if (done) begin
					if (PRIMARY_INITIATION_INPUT) begin
						ld_sched   = 1'b1;
						repeat_ld  = 1'b1;
						sched_next = home_reg;
						state_next = wsv_pkg::ST_LOAD;
					end else begin
						state_next = wsv_pkg::ST_IDLE;
					end
				end
			end
			default: state_next = wsv_pkg::ST_IDLE;
		endcase
		// exit inputs redirect a parked sequence
		if (parked && (ex1_rise || ex2_rise)) begin
			ld_sched    = 1'b1;
			ld_cnt      = 1'b0;
			clr_primary = 1'b1;
			sched_next  = ex1_rise ? `WSV_EXIT1_SCHED : `WSV_EXIT2_SCHED;
			state_next  = wsv_pkg::ST_LOAD;
		end
		// stop opening ends any running sequence, parked or not
		if (stop && state_reg != wsv_pkg::ST_IDLE) begin
			state_next = wsv_pkg::ST_IDLE;
			ld_sched   = 1'b0;
			csw_next   = 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			start_prev <= 1'b1;
			ex1_prev   <= 1'b1;
			ex2_prev   <= 1'b1;
		end else begin
			start_prev <= PRIMARY_INITIATION_INPUT;
			ex1_prev   <= WAIT_EXIT_INPUT_FIRST;
			ex2_prev   <= WAIT_EXIT_INPUT_SECOND;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			state_reg <= wsv_pkg::ST_IDLE;
			csw_reg   <= 1'b0;
			cnt_reg   <= 7'h00;
		end else begin
			state_reg <= state_next;
			csw_reg   <= csw_next;
			if (ld_cnt)
				cnt_reg <= cnt_val;
			else if (LINE_TICK && !done && (!parked || imp_park))
				cnt_reg <= cnt_reg - 7'h01;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			sched_reg      <= 6'h00;
			home_reg       <= 6'h00;
			pend_reg       <= 6'h00;
			pend_valid_reg <= 1'b0;
			primary_reg    <= 1'b0;
			up_ok_reg      <= 1'b0;
			rec_reg        <= '0;
			next_pct_reg   <= 7'h00;
			imp_reg        <= 7'h00;
		end else begin
			if (ld_sched)
				sched_reg <= sched_next;
			if (state_reg == wsv_pkg::ST_IDLE && start_rise) begin
				home_reg       <= sched_next;
				pend_valid_reg <= 1'b0;
				primary_reg    <= 1'b1;
			end else if (clr_primary) begin
				primary_reg <= 1'b0;
			end
			if (set_pend) begin
				pend_reg       <= sched_reg + 6'h01;
				pend_valid_reg <= 1'b1;
			end
			if (ld_sched)
				up_ok_reg <= !repeat_ld;
			if (state_reg == wsv_pkg::ST_LOAD) begin
				rec_reg      <= REC;
				next_pct_reg <= REC_NEXT.pct;
				imp_reg      <= REC.impulses;
			end else if (state_reg == wsv_pkg::ST_COOL && done && !imp_park) begin
				imp_reg <= imp_reg - 7'h01;
			end
		end
	end

	// current ramp toward the firing stage
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			cur_reg    <= 7'h00;
			end_reg    <= 7'h00;
			step_reg   <= 7'h00;
			dir_up_reg <= 1'b1;
		end else if (state_next == wsv_pkg::ST_UPS && state_reg != wsv_pkg::ST_UPS) begin
			cur_reg    <= up_s;
			end_reg    <= up_e;
			step_reg   <= ramp_step;
			dir_up_reg <= (up_e >= up_s);
		end else if (state_next == wsv_pkg::ST_DNS && state_reg != wsv_pkg::ST_DNS) begin
			cur_reg    <= rec_reg.pct;
			end_reg    <= {2'h0, rec_reg.pct[6:2]};
			step_reg   <= ramp_step;
			dir_up_reg <= 1'b0;
		end else if (state_next == wsv_pkg::ST_WELD) begin
			cur_reg <= rec_reg.pct;
		end else if (state_reg == wsv_pkg::ST_UPS || state_reg == wsv_pkg::ST_DNS) begin
			if (done)
				cur_reg <= end_reg;
			else if (LINE_TICK)
				cur_reg <= dir_up_reg ? cur_reg + step_reg : cur_reg - step_reg;
		end
	end

	// hold indicator blink while waiting for re-initiation
	always_ff @(posedge CORE_CLK) begin
		if (RST || !csw_reg) begin
			blink_cnt <= 9'h000;
			blink_reg <= 1'b0;
		end else if (LINE_TICK) begin
			if (blink_cnt == `WSV_BLINK_TICKS) begin
				blink_cnt <= 9'h000;
				blink_reg <= ~blink_reg;
			end else begin
				blink_cnt <= blink_cnt + 9'h001;
			end
		end
	end

	always_comb begin
		drv_next = '0;
		if (state_next != wsv_pkg::ST_IDLE && state_reg != wsv_pkg::ST_IDLE)
			drv_next.valve = (state_reg == wsv_pkg::ST_LOAD) ? REC.valve : rec_reg.valve;
		drv_next.fire = (state_reg == wsv_pkg::ST_UPS || state_reg == wsv_pkg::ST_WELD
			|| state_reg == wsv_pkg::ST_DNS);
		drv_next.current = drv_next.fire ? cur_reg : 7'h00;
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			VALVE       <= 3'h0;
			FIRE        <= 1'b0;
			CURRENT_PCT <= 7'h00;
			SCHED_NUM   <= 6'h00;
			PHASE       <= wsv_pkg::ST_IDLE;
			WAITING     <= 1'b0;
			HOLD_BLINK  <= 1'b0;
		end else begin
			VALVE       <= drv_next.valve;
			FIRE        <= drv_next.fire;
			CURRENT_PCT <= drv_next.current;
			SCHED_NUM   <= ld_sched ? sched_next : sched_reg;
			PHASE       <= state_reg;
			WAITING     <= parked;
			HOLD_BLINK  <= blink_reg;
		end
	end
endmodule

// File: testbench/wsv_store_model.sv
// schedule store model: records for the current and the next schedule
// assumes SCHED_NUM from the sequencer; answers at once, records fixed
`timescale 1ns/100ps
module wsv_store_model (
	// schedule number in
	input  wire logic [5:0]     SCHED_NUM,
	// records out
	output wsv_pkg::wsv_sched_t REC,
	output wsv_pkg::wsv_sched_t REC_NEXT
);
	function automatic wsv_pkg::wsv_sched_t rec_of(input logic [5:0] n);
		wsv_pkg::wsv_sched_t r;
		r = '0;
		r.squeeze = 7'h02;
		r.weld = 7'h03;
		r.hold = 7'h02;
		r.impulses = 7'h01;
		r.cool = 7'h01;
		r.pct = 7'h28;
		case (n)
		6'h01: r.valve = 3'h5;
		6'h02: begin
			r.weld = 7'h02;
			r.pct = 7'h3C;
			r.valve = 3'h7;
			r.slope_mode = 2'h1;
			r.slope_count = 7'h09;
		end
		6'h03: begin
			r.valve = 3'h3;
			r.cycle_mode = 3'h5;
			r.impulses = 7'h63;
		end
		6'h04: begin
			r.valve = 3'h6;
			r.cycle_mode = 3'h5;
			r.hold = 7'h63;
		end
		6'h05: begin
			r.valve = 3'h4;
			r.cycle_mode = 3'h5;
			r.squeeze = 7'h63;
			r.impulses = 7'h63;
		end
		6'h06: begin
			r.pct = 7'h50;
			r.cycle_mode = 3'h2;
			r.slope_mode = 2'h2;
			r.slope_count = 7'h0A;
		end
		6'h08: begin
			r.valve = 3'h6;
			r.cycle_mode = 3'h4;
		end
		6'h0A: r.valve = 3'h1;
		6'h14: r.valve = 3'h2;
		default: r.valve = 3'h0;
		endcase
		return r;
	endfunction
	always_comb REC = rec_of(SCHED_NUM);
	always_comb REC_NEXT = rec_of(SCHED_NUM + 6'h01);
endmodule

// File: testbench/wsv_top_monitor.sv
// checker for the weld schedule sequencer, top-level ports only
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/100ps
module wsv_top_monitor (
	// clock and reset
	input wire logic                CORE_CLK,
	input wire logic                RST,
	// inputs
	input wire logic                ESTOP_CLOSED,
	input wire logic                TEMP_LIMIT_CLOSED,
	input wire logic                WAIT_EXIT_INPUT_FIRST,
	input wire logic                WAIT_EXIT_INPUT_SECOND,
	input wire logic [6:0]          WAIT_MODE_ENABLE,
	input wire wsv_pkg::wsv_sched_t REC,
	// outputs
	input wire logic [5:0]          SCHED_NUM,
	input wire logic [2:0]          VALVE,
	input wire logic                FIRE,
	input wire logic [6:0]          CURRENT_PCT,
	input wire logic [8:0]          PHASE,
	input wire logic                WAITING
);
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	// settled park only: an exit renames the schedule one clock early
	sequence s_parked;
		WAITING && $past(WAITING) && $stable(SCHED_NUM);
	endsequence
	chk_reset_clears: assert property ($past(RST) |-> VALVE == 3'h0 && !FIRE && !WAITING)
		else $error("outputs not cleared by reset");
	chk_valve_decode: assert property (PHASE == 9'h004 && $past(PHASE) == 9'h004 &&
		$stable(SCHED_NUM) && $past(ESTOP_CLOSED && TEMP_LIMIT_CLOSED) |-> VALVE == REC.valve)
		else $error("valve code not decoded");
	chk_fire_current: assert property (!FIRE |-> CURRENT_PCT == 7'h00)
		else $error("current without firing");
	chk_stop_abort: assert property ((!ESTOP_CLOSED || !TEMP_LIMIT_CLOSED) |->
		##[1:3] (!WAITING && !FIRE && VALVE == 3'h0))
		else $error("stop did not abort");
	chk_wait_enable: assert property ($rose(WAITING) |-> WAIT_MODE_ENABLE == 7'h05)
		else $error("wait without enable");
	chk_wait_valves: assert property (WAITING && $past(WAITING)
		&& $past(ESTOP_CLOSED && TEMP_LIMIT_CLOSED) |-> $stable(VALVE))
		else $error("valves moved while parked");
	chk_park_squeeze: assert property (s_parked ##0 REC.squeeze == 7'h63 |-> PHASE == 9'h004)
		else $error("squeeze park wrong");
	chk_park_weld: assert property (s_parked ##0 REC.squeeze != 7'h63 && REC.impulses == 7'h63
		|-> PHASE inside {9'h010, 9'h020})
		else $error("weld park wrong");
	chk_park_hold: assert property (s_parked ##0 REC.squeeze != 7'h63 &&
		REC.impulses != 7'h63 && REC.hold == 7'h63 |-> PHASE == 9'h080)
		else $error("hold park wrong");
	chk_exit_first: assert property (WAITING && $rose(WAIT_EXIT_INPUT_FIRST) |->
		##[1:3] SCHED_NUM == 6'h0A)
		else $error("first exit schedule wrong");
	chk_exit_second: assert property (WAITING && $rose(WAIT_EXIT_INPUT_SECOND) &&
		!WAIT_EXIT_INPUT_FIRST |-> ##[1:3] SCHED_NUM == 6'h14)
		else $error("second exit schedule wrong");
	cov_park: cover property ($rose(WAITING));
	cov_upslope: cover property (FIRE && PHASE == 9'h008);
	cov_stop_parked: cover property (WAITING && $fell(ESTOP_CLOSED));
endmodule
bind wsv_top wsv_top_monitor mon (
	.CORE_CLK(CORE_CLK),
	.RST(RST),
	.ESTOP_CLOSED(ESTOP_CLOSED),
	.TEMP_LIMIT_CLOSED(TEMP_LIMIT_CLOSED),
	.WAIT_EXIT_INPUT_FIRST(WAIT_EXIT_INPUT_FIRST),
	.WAIT_EXIT_INPUT_SECOND(WAIT_EXIT_INPUT_SECOND),
	.WAIT_MODE_ENABLE(WAIT_MODE_ENABLE),
	.REC(REC),
	.SCHED_NUM(SCHED_NUM),
	.VALVE(VALVE),
	.FIRE(FIRE),
	.CURRENT_PCT(CURRENT_PCT),
	.PHASE(PHASE),
	.WAITING(WAITING)
);

// File: testbench/tb.sv
// testbench for the weld schedule sequencer with the store model
// assumes a line tick every four clocks
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
	$display("wrong value at %0t: %h vs %h", $time, a, b); end end
module tb;
	logic                clk, rst, tick, start_in, exit1, exit2, estop_ok, temp_ok;
	logic [6:0]          wait_en, cur;
	logic [5:0]          sel, sched_num;
	logic [2:0]          valve;
	logic                fire, waiting, blink;
	logic [8:0]          phase;
	logic [1:0]          tick_cnt;
	wsv_pkg::wsv_sched_t rec, rec_next;
	int                  err_count, compares;
	wsv_top uut (.CORE_CLK(clk), .RST(rst), .LINE_TICK(tick), .PRIMARY_INITIATION_INPUT(start_in),
		.WAIT_EXIT_INPUT_FIRST(exit1), .WAIT_EXIT_INPUT_SECOND(exit2), .ESTOP_CLOSED(estop_ok),
		.TEMP_LIMIT_CLOSED(temp_ok), .WAIT_MODE_ENABLE(wait_en), .SCHED_SELECT(sel), .REC(rec),
		.REC_NEXT(rec_next), .SCHED_NUM(sched_num), .VALVE(valve), .FIRE(fire),
		.CURRENT_PCT(cur), .PHASE(phase), .WAITING(waiting), .HOLD_BLINK(blink));
	wsv_store_model store (.SCHED_NUM(sched_num), .REC(rec), .REC_NEXT(rec_next));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		tick_cnt <= tick_cnt + 2'h1;
		tick <= (tick_cnt == 2'h3);
	end
	task automatic report_and_stop;
		if (err_count == 0 && compares > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// 0 idle, 1 parked, 2 firing; a hang counts as a mismatch
	task automatic wait_for(input int c);
		for (int n = 0; !(c == 0 ? phase === 9'h001 : c == 1 ? waiting === 1'b1 :
				fire === 1'b1); n++) begin
			@(posedge clk);
			#1;
			if (n > 20000) begin
				err_count++;
				report_and_stop();
			end
		end
	endtask
	// follows the setpoint while firing; every change must be one step of d
	task automatic ramp(input logic [6:0] d, output int steps, output logic [6:0] e);
		e = cur;
		steps = 0;
		for (int n = 0; n < 400 && fire === 1'b1; n++) begin
			@(posedge clk);
			#1;
			if (fire === 1'b1 && cur !== e) begin
				e = e + d;
				steps++;
				`CHK(cur, e)
			end
		end
	endtask
	task automatic start(input logic [5:0] s);
		@(posedge clk);
		sel <= s;
		start_in <= 1'b1;
		repeat (4) @(posedge clk);
		start_in <= 1'b0;
	endtask
	task automatic t_plain_and_up;
		logic [6:0] e;
		int         steps;
		start(6'h01);
		wait_for(2);
		`CHK(cur, 7'h28)
		`CHK(valve, 3'h5)
		wait_for(0);
		start(6'h02);
		wait_for(2);
		`CHK(valve, 3'h7)
		`CHK(cur, 7'h0F)
		ramp(7'h05, steps, e);
		`CHK(steps, 9)
		`CHK(e, 7'h3C)
		wait_for(0);
		start(6'h06);
		wait_for(2);
		`CHK(cur, 7'h50)
		ramp(7'h7A, steps, e);
		`CHK(steps, 10)
		`CHK(e, 7'h14)
		wait_for(0);
		`CHK(sched_num, 6'h07)
		wait_for(0);
	endtask
	task automatic t_park_exit(input logic [5:0] s);
		int   fires;
		logic last;
		start(s);
		wait_for(1);
		fires = 0;
		last = fire;
		repeat (200) begin
			@(posedge clk);
			#1;
			if (fire === 1'b1 && last !== 1'b1) fires++;
			last = fire;
		end
		`CHK(waiting, 1'b1)
		if (s == 6'h03) `CHK(fires > 10, 1'b1)
		else `CHK(phase, 9'h080)
		@(posedge clk);
		if (s == 6'h03) exit1 <= 1'b1;
		else exit2 <= 1'b1;
		repeat (3) @(posedge clk);
		exit1 <= 1'b0;
		exit2 <= 1'b0;
		#1;
		`CHK(sched_num, s == 6'h03 ? 6'h0A : 6'h14)
		wait_for(0);
	endtask
	task automatic t_park_stop;
		for (int k = 0; k < 2; k++) begin
			start(k == 0 ? 6'h05 : 6'h03);
			wait_for(1);
			repeat (3) @(posedge clk);
			#1;
			if (k == 0) `CHK(phase, 9'h004)
			@(posedge clk);
			estop_ok <= (k != 0);
			temp_ok <= (k == 0);
			repeat (3) @(posedge clk);
			#1;
			`CHK(waiting, 1'b0)
			`CHK(valve, 3'h0)
			@(posedge clk);
			estop_ok <= 1'b1;
			temp_ok <= 1'b1;
		end
	endtask
	// blink toggles about 1000 clocks after hold ends, then again every 1000 clocks
	task automatic t_cond_succ;
		start(6'h08);
		repeat (1200) @(posedge clk);
		#1;
		`CHK(phase, 9'h080)
		`CHK(valve, 3'h6)
		`CHK(blink, 1'b1)
		start(6'h08);
		wait_for(0);
		`CHK(sched_num, 6'h09)
	endtask
	task automatic t_no_enable;
		logic seen;
		wait_en <= 7'h00;
		start(6'h03);
		seen = 1'b0;
		for (int n = 0; n < 3000 && phase !== 9'h001; n++) begin
			@(posedge clk);
			#1;
			if (waiting === 1'b1) seen = 1'b1;
		end
		`CHK(seen, 1'b0)
		`CHK(phase, 9'h001)
	endtask
	initial begin
		{rst, estop_ok, temp_ok} = 3'h7;
		{tick, start_in, exit1, exit2, tick_cnt} = 6'h00;
		wait_en = 7'h05;
		sel = 6'h00;
		err_count = 0;
		compares = 0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		`CHK(valve, 3'h0)
		t_plain_and_up();
		t_park_exit(6'h03);
		t_park_exit(6'h04);
		t_park_stop();
		t_no_enable();
		t_cond_succ();
		report_and_stop();
	end
endmodule
